/* File: logic/csc_pkg.sv */
// constants, register layout and carrier types of the card socket control register bank
//
// Behaviour
// [R01] ring enable routes ring to its terminals
// [R02] video float bit tristates socket video terminals
// [R03] port select picks video priority socket
// [R04] card control bits four, three read zero
// [R05] audio route bit sends card audio out
// [R06] both audio routes set: socket zero wins
// [R07] speaker enable; output is xor of sockets
// [R08] speaker terminal driven while any enable set
// [R09] per-socket flag set on functional interrupt
// [R10] writing one clears flag; zero keeps it
// [R11] software touches ring enable via function zero
// [R12] capability force bit, reset one
// [R13] device control bit five diagnostic, reset one
// [R14] device control bit four reads zero, ignores writes
// [R15] software writes zero to test bit three
// [R16] bits two..one select interrupt signalling, reset three
// [R17] software writes zero to device bit zero
// [R18] global device bits accessed via function zero
// [R19] device control bit seven reads zero
// [R20] software writes only zeros to diagnostic
// [R21] ring enable is one shared storage bit
// [R22] speaker terminal floats when no enable set
package csc_pkg;

	// ****************************************
	// bus geometry
	// ****************************************
	localparam int ADDR_W = 12;                  // axi4-lite address width
	localparam int DATA_W = 32;                  // axi4-lite data width
	localparam int IDX_LSB = 2;                  // word index starts above byte lanes
	localparam int IDX_MSB = 9;                  // eight index bits
	localparam int FUNC_BIT = 10;                // selects socket function 0 or 1
	localparam int TOP_BIT = 11;                 // must be zero for a mapped address
	localparam logic [1:0] RESP_OKAY = 2'h0;     // normal answer
	localparam logic [1:0] RESP_SLVERR = 2'h2;   // unmapped address answer

	// ****************************************
	// register indices (byte address is four times)
	// ****************************************
	localparam logic [7:0] IDX_CARD_CTRL = 8'h91;
	localparam logic [7:0] IDX_DEV_CTRL = 8'h92;
	localparam logic [7:0] IDX_DIAG = 8'h93;

	// ****************************************
	// card routing control fields
	// ****************************************
	localparam int CC_RING_EN = 7;
	localparam int CC_VID_FLOAT = 6;
	localparam int CC_PORT_SEL = 5;
	localparam int CC_AUD_ROUTE = 2;
	localparam int CC_SPK_EN = 1;
	localparam int CC_IRQ_FLAG = 0;

	// ****************************************
	// device control fields and reset values
	// ****************************************
	localparam int DC_LV_FORCE = 6;
	localparam int DC_MODE_LSB = 1;
	localparam int DC_MODE_MSB = 2;
	localparam logic [7:0] DC_WR_MASK = 8'h6f;   // bits 7 and 4 are not stored
	localparam logic [7:0] DC_RESET = 8'h66;
	localparam logic [7:0] DIAG_RESET = 8'h61;

	// per-function card control state
	typedef struct packed {
		logic video_float;
		logic port_sel;
		logic audio_route;
		logic speaker_en;
		logic irq_flag;
	} csc_card_ctrl_type;

	// socket-side pins, one bit per socket
	typedef struct packed {
		logic [1:0] ring;
		logic [1:0] audio;
		logic [1:0] speaker;
		logic [1:0] func_irq;
	} csc_socket_pins_type;

	localparam csc_card_ctrl_type CC_RESET = '{default: 1'b0};

endpackage

/* File: logic/csc_card_socket_regs.sv */
// card socket control register bank with axi4-lite slave and socket signal routing
`timescale 1ns/1ps
module csc_card_socket_regs
	import csc_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// socket pins and neighbouring logic
	input wire csc_socket_pins_type socket_pins_i,
	input wire logic ring_mux_select_i,
	output logic ring_indicate_out_o,
	output logic ring_mfunc_out_o,
	output logic [1:0] video_port_float_en_o,
	output logic video_sel_sock0_o,
	output logic video_sel_sock1_o,
	output logic card_audio_pwm_out_o,
	output logic speaker_out_pin_o,
	output logic speaker_out_oe_o,
	output logic [1:0] card_func_irq_flag_o,
	output logic low_volt_capable_force_o,
	output logic [1:0] irq_signal_mode_o
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	csc_socket_pins_type pins_meta; // first stage, read only by pins_sync
	csc_socket_pins_type pins_sync; // safe to use

	// socket pins are asynchronous to the bus clock
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			pins_meta <= '0;
			pins_sync <= '0;
		end else begin
			pins_meta <= socket_pins_i;
			pins_sync <= pins_meta;
		end
	end

	// ****************************************
	// register state
	// ****************************************
	csc_card_ctrl_type card_ctrl [2];       // one set per socket function
	csc_card_ctrl_type next_card_ctrl [2];
	logic ring_en;                          // shared by both functions
	logic next_ring_en;
	logic [7:0] dev_ctrl;                   // global device control
	logic [7:0] next_dev_ctrl;
	logic [7:0] diag;                       // global diagnostic
	logic [7:0] next_diag;

	// ****************************************
	// bus channel state
	// ****************************************
	logic aw_held, next_aw_held;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic w_held, next_w_held;
	logic [7:0] w_byte, next_w_byte;        // only the low lane carries data
	logic w_lane0, next_w_lane0;
	logic awready, next_awready;
	logic wready, next_wready;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic arready, next_arready;
	logic rvalid, next_rvalid;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;

	// write strobes, per function for card control, decoded from the held address
	logic write_go;
	logic wr_hit;
	logic wr_func;
	logic [7:0] wr_idx;
	logic [1:0] wr_card;
	logic wr_dev;
	logic wr_diag;

	// ****************************************
	// write decode
	// ****************************************
	// a write is carried out once address and data are both held
	always_comb begin
		write_go = aw_held && w_held && !bvalid;
		wr_func = aw_addr[FUNC_BIT];
		wr_idx = aw_addr[IDX_MSB:IDX_LSB];
		wr_hit = !aw_addr[TOP_BIT] &&
			(wr_idx == IDX_CARD_CTRL || wr_idx == IDX_DEV_CTRL || wr_idx == IDX_DIAG);
		// a write with the low lane off touches nothing but still answers
		wr_card[0] = write_go && w_lane0 && !wr_func && wr_idx == IDX_CARD_CTRL && wr_hit;
		wr_card[1] = write_go && w_lane0 && wr_func && wr_idx == IDX_CARD_CTRL && wr_hit;
		wr_dev = write_go && w_lane0 && wr_hit && wr_idx == IDX_DEV_CTRL;
		wr_diag = write_go && w_lane0 && wr_hit && wr_idx == IDX_DIAG;
	end

	// ****************************************
	// per-function card control
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_func
			// bits 4..3 have no storage, so they read zero [R04]
			always_comb begin
				next_card_ctrl[g] = card_ctrl[g];
				if (wr_card[g]) begin
					next_card_ctrl[g].video_float = w_byte[CC_VID_FLOAT];
					next_card_ctrl[g].port_sel = w_byte[CC_PORT_SEL];
					next_card_ctrl[g].audio_route = w_byte[CC_AUD_ROUTE];
					next_card_ctrl[g].speaker_en = w_byte[CC_SPK_EN];
				end
				// write-one clears, a zero keeps it [R10]
				if (wr_card[g] && w_byte[CC_IRQ_FLAG]) begin
					next_card_ctrl[g].irq_flag = 1'b0;
				end
				// a new interrupt wins over a clear in the same cycle [R09]
				if (pins_sync.func_irq[g]) begin
					next_card_ctrl[g].irq_flag = 1'b1;
				end
			end

			always_ff @(posedge clock_i) begin
				if (sys_rst_i) begin
					card_ctrl[g] <= CC_RESET;
				end else begin
					card_ctrl[g] <= next_card_ctrl[g];
				end
			end
		end
	endgenerate

	// ****************************************
	// global registers
	// ****************************************
	// either function reaches the same storage; software is expected to use function 0 [R11] [R18]
	always_comb begin
		next_ring_en = ring_en;
		next_dev_ctrl = dev_ctrl;
		next_diag = diag;
		if (wr_card[0] || wr_card[1]) begin
			next_ring_en = w_byte[CC_RING_EN]; // [R21]
		end
		if (wr_dev) begin
			// bits 7 and 4 stay zero and ignore writes [R14] [R19]
			next_dev_ctrl = w_byte & DC_WR_MASK; // [R12] [R13] [R16]
		end
		if (wr_diag) begin
			// stored as written; zeros only is a software duty [R20]
			next_diag = w_byte;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ring_en <= 1'b0;
			dev_ctrl <= DC_RESET;
			diag <= DIAG_RESET;
		end else begin
			ring_en <= next_ring_en;
			dev_ctrl <= next_dev_ctrl;
			diag <= next_diag;
		end
	end

	// ****************************************
	// read data mux
	// ****************************************
	function automatic logic [8:0] read_reg(input logic [ADDR_W-1:0] addr);
		logic [7:0] idx;
		csc_card_ctrl_type cc;
		idx = addr[IDX_MSB:IDX_LSB];
		cc = addr[FUNC_BIT] ? card_ctrl[1] : card_ctrl[0];
		read_reg = '0;
		if (!addr[TOP_BIT]) begin
			case (idx)
				IDX_CARD_CTRL: begin
					read_reg = {1'b1, ring_en, cc.video_float, cc.port_sel, 2'b00,
						cc.audio_route, cc.speaker_en, cc.irq_flag};
				end
				IDX_DEV_CTRL: begin
					read_reg = {1'b1, dev_ctrl};
				end
				IDX_DIAG: begin
					read_reg = {1'b1, diag};
				end
				default: begin
					read_reg = '0;
				end
			endcase
		end
	endfunction

	// ****************************************
	// axi4-lite channel handling
	// ****************************************
	// ready outputs are registered, so each is computed from the next held state
	always_comb begin
		logic [8:0] rd;
		rd = read_reg(s_axi_araddr_i);
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_byte = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		// address and data are taken in either order
		if (s_axi_awvalid_i && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready) begin
			next_w_held = 1'b1;
			next_w_byte = s_axi_wdata_i[7:0];
			next_w_lane0 = s_axi_wstrb_i[0];
		end
		// response follows the commit, then waits for bready
		if (write_go) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && s_axi_bready_i) begin
			next_bvalid = 1'b0;
		end
		// one read at a time; data captured the cycle the address is taken
		if (s_axi_arvalid_i && arready) begin
			next_rvalid = 1'b1;
			next_rdata = {24'h000000, rd[7:0]};
			next_rresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && s_axi_rready_i) begin
			next_rvalid = 1'b0;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_byte <= next_w_byte;
			w_lane0 <= next_w_lane0;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// ****************************************
	// socket signal routing
	// ****************************************
	logic next_ring_pme, next_ring_mfunc;
	logic next_sel0, next_sel1;
	logic next_audio, next_spk, next_spk_oe;
	logic ring_pme_q, ring_mfunc_q, sel0_q, sel1_q, audio_q, spk_q, spk_oe_q;

	// all routed outputs but video_port_float_en_o are computed here and registered below
	always_comb begin
		logic ring_any;
		logic [1:0] spk_gated;
		ring_any = |pins_sync.ring;
		// ring goes nowhere while the shared enable is clear [R01]
		next_ring_pme = ring_en && !ring_mux_select_i && ring_any; // [R01]
		next_ring_mfunc = ring_en && ring_any; // [R01]
		// video select: single active socket wins, both active use port select [R03]
		next_sel0 = 1'b0;
		next_sel1 = 1'b0;
		if (card_ctrl[0].video_float && card_ctrl[1].video_float) begin
			next_sel0 = !card_ctrl[0].port_sel; // [R03]
			next_sel1 = card_ctrl[0].port_sel; // [R03]
		end else begin
			next_sel0 = card_ctrl[0].video_float;
			next_sel1 = card_ctrl[1].video_float;
		end
		// socket 0 takes precedence when both route audio [R05] [R06]
		if (card_ctrl[0].audio_route) begin
			next_audio = pins_sync.audio[0]; // [R06]
		end else if (card_ctrl[1].audio_route) begin
			next_audio = pins_sync.audio[1]; // [R05]
		end else begin
			next_audio = 1'b0;
		end
		// each socket's speaker input only counts while its enable is set [R07]
		spk_gated[0] = pins_sync.speaker[0] && card_ctrl[0].speaker_en;
		spk_gated[1] = pins_sync.speaker[1] && card_ctrl[1].speaker_en;
		next_spk = spk_gated[0] ^ spk_gated[1]; // [R07]
		// pin floats unless some function enables it [R08] [R22]
		next_spk_oe = card_ctrl[0].speaker_en || card_ctrl[1].speaker_en;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ring_pme_q <= 1'b0;
			ring_mfunc_q <= 1'b0;
			sel0_q <= 1'b0;
			sel1_q <= 1'b0;
			audio_q <= 1'b0;
			spk_q <= 1'b0;
			spk_oe_q <= 1'b0;
		end else begin
			ring_pme_q <= next_ring_pme;
			ring_mfunc_q <= next_ring_mfunc;
			sel0_q <= next_sel0;
			sel1_q <= next_sel1;
			audio_q <= next_audio;
			spk_q <= next_spk;
			spk_oe_q <= next_spk_oe;
		end
	end

	// ****************************************
	// output ports (all flip-flops)
	// ****************************************
	assign s_axi_awready_o = awready;
	assign s_axi_wready_o = wready;
	assign s_axi_bvalid_o = bvalid;
	assign s_axi_bresp_o = bresp;
	assign s_axi_arready_o = arready;
	assign s_axi_rvalid_o = rvalid;
	assign s_axi_rdata_o = rdata;
	assign s_axi_rresp_o = rresp;
	assign ring_indicate_out_o = ring_pme_q;
	assign ring_mfunc_out_o = ring_mfunc_q;
	// video terminals float while the socket bit is set [R02]
	assign video_port_float_en_o = {card_ctrl[1].video_float, card_ctrl[0].video_float}; // [R02]
	assign video_sel_sock0_o = sel0_q;
	assign video_sel_sock1_o = sel1_q;
	assign card_audio_pwm_out_o = audio_q;
	assign speaker_out_pin_o = spk_q;
	assign speaker_out_oe_o = spk_oe_q;
	assign card_func_irq_flag_o = {card_ctrl[1].irq_flag, card_ctrl[0].irq_flag};
	assign low_volt_capable_force_o = dev_ctrl[DC_LV_FORCE]; // [R12]
	assign irq_signal_mode_o = dev_ctrl[DC_MODE_MSB:DC_MODE_LSB]; // [R16]

endmodule // csc_card_socket_regs

/* File: tb/csc_socket_model.sv */
// socket-side model: card pin levels as the two sockets present them to the bridge
`timescale 1ns/1ps
module csc_socket_model
	import csc_pkg::*;
(
	input wire logic clock_i,
	input wire csc_socket_pins_type level_i, // levels the cards are told to show
	output csc_socket_pins_type pins_o // card pins toward the bridge
);
	// ****************************************
	// pin launch
	// ****************************************
	// pins move just after an edge, like a real card, so the bridge synchroniser sees clean levels
	always_ff @(posedge clock_i) begin
		pins_o <= level_i;
	end
endmodule // csc_socket_model

/* File: tb/csc_card_socket_regs_sva.sv */
// port checker of the card socket control register bank, bound to the top module
`timescale 1ns/1ps
module csc_card_socket_regs_sva
	import csc_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [DATA_W-1:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire csc_socket_pins_type socket_pins_i,
	input wire logic ring_mux_select_i,
	input wire logic ring_indicate_out_o,
	input wire logic ring_mfunc_out_o,
	input wire logic video_sel_sock0_o,
	input wire logic video_sel_sock1_o,
	input wire logic speaker_out_pin_o,
	input wire logic speaker_out_oe_o,
	input wire logic [1:0] card_func_irq_flag_o,
	input wire logic low_volt_capable_force_o,
	input wire logic [1:0] irq_signal_mode_o
);
	// ****************************************
	// one clock domain for every check
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// both write channels taken at one edge, as the bench master offers them
	sequence wr_take_s;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// read of an address with the top bit set lands outside the map
	sequence rd_bad_s;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[TOP_BIT];
	endsequence
	reset_values_a: assert property ($fell(sys_rst_i) |-> irq_signal_mode_o == 2'h3 && low_volt_capable_force_o)
		else $error("device control outputs wrong after reset");
	ring_mux_a: assert property (ring_indicate_out_o |-> ring_mfunc_out_o && !$past(ring_mux_select_i))
		else $error("ring output routed against mux select");
	video_sel_a: assert property (!(video_sel_sock0_o && video_sel_sock1_o))
		else $error("both video selects active");
	spk_float_a: assert property (!speaker_out_oe_o |-> !speaker_out_pin_o)
		else $error("speaker level while not driving");
	irq_set_a: assert property (socket_pins_i.func_irq[0] [*4] |=> card_func_irq_flag_o[0])
		else $error("interrupt flag missed a functional interrupt");
	wr_answer_a: assert property (wr_take_s |-> ##2 s_axi_bvalid_o)
		else $error("write answer late");
	b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped");
	rd_bad_a: assert property (rd_bad_s |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped");
endmodule // csc_card_socket_regs_sva
bind csc_card_socket_regs csc_card_socket_regs_sva chk_u (.clock_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.socket_pins_i, .ring_mux_select_i, .ring_indicate_out_o, .ring_mfunc_out_o, .video_sel_sock0_o,
	.video_sel_sock1_o, .speaker_out_pin_o, .speaker_out_oe_o, .card_func_irq_flag_o, .low_volt_capable_force_o,
	.irq_signal_mode_o);

/* File: tb/tb.sv */
// self-checking bench of the card socket control register bank
`timescale 1ns/1ps
module tb;
	import csc_pkg::*;
	logic clock_i, sys_rst_i, ring_mux_select_i; // clock, reset, ring mux level
	logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i; // bus addresses
	logic [DATA_W-1:0] s_axi_wdata_i, s_axi_rdata_o; // bus data
	logic [3:0] s_axi_wstrb_i; // byte strobes
	logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
	logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, video_port_float_en_o, card_func_irq_flag_o, irq_signal_mode_o;
	logic ring_indicate_out_o, ring_mfunc_out_o, video_sel_sock0_o, video_sel_sock1_o, card_audio_pwm_out_o;
	logic speaker_out_pin_o, speaker_out_oe_o, low_volt_capable_force_o;
	csc_socket_pins_type lvl, socket_pins_i; // wanted card levels, card pins
	int miscompares, total_checks, cycles, m; // counters, loop index
	logic [7:0] v; // register value under test
	logic [31:0] d; // read data
	logic [1:0] r; // read response
	csc_socket_model sock_u (.clock_i, .level_i(lvl), .pins_o(socket_pins_i));
	csc_card_socket_regs dut_u (.clock_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
		.s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
		.s_axi_rvalid_o, .s_axi_rready_i, .socket_pins_i, .ring_mux_select_i, .ring_indicate_out_o,
		.ring_mfunc_out_o, .video_port_float_en_o, .video_sel_sock0_o, .video_sel_sock1_o, .card_audio_pwm_out_o,
		.speaker_out_pin_o, .speaker_out_oe_o, .card_func_irq_flag_o, .low_volt_capable_force_o,
		.irq_signal_mode_o);
	// ****************************************
	// helpers
	// ****************************************
	initial begin
		clock_i = 0;
		forever #2.5 clock_i = ~clock_i;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard: the whole run needs a few hundred cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// write: both channels offered together, bready held until the answer
	// each channel is released at the edge where its own ready is seen high
	task wr(input logic [11:0] a, input logic [7:0] dd, input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge clock_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {24'h0, dd};
		s_axi_awvalid_i <= 1;
		s_axi_wvalid_i <= 1;
		s_axi_bready_i <= 1;
		while (!(aw_done && w_done)) begin
			@(posedge clock_i);
			if (!aw_done && s_axi_awready_o === 1) begin
				aw_done = 1;
				s_axi_awvalid_i <= 0;
			end
			if (!w_done && s_axi_wready_o === 1) begin
				w_done = 1;
				s_axi_wvalid_i <= 0;
			end
		end
		do @(posedge clock_i); while (s_axi_bvalid_o !== 1);
		s_axi_bready_i <= 0;
		chk("bresp", er, s_axi_bresp_o);
	endtask
	task rd(input logic [11:0] a);
		@(posedge clock_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1;
		s_axi_rready_i <= 1;
		do @(posedge clock_i); while (s_axi_arready_o !== 1);
		s_axi_arvalid_i <= 0;
		do @(posedge clock_i); while (s_axi_rvalid_o !== 1);
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
		s_axi_rready_i <= 0;
	endtask
	task rc(input logic [11:0] a, input logic [7:0] e);
		rd(a);
		chk("rresp", RESP_OKAY, r);
		chk("rdata", {24'h0, e}, d);
	endtask
	// pins need sync plus output flop before they show
	task settle;
		repeat (6) @(posedge clock_i);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		rc(12'h248, 8'h66);
		rc(12'h24c, 8'h61);
		rc(12'h244, 8'h00);
		chk("mode", 2'h3, irq_signal_mode_o);
		chk("lv", 1, low_volt_capable_force_o);
	endtask
	task t_dev;
		for (m = 0; m < 4; m++) begin
			v = {1'b1, m[0], m[1], 1'b1, 1'b0, m[1:0], 1'b0};
			wr(12'h248, v, RESP_OKAY);
			rc(12'h648, v & 8'h6e);
			chk("mode", m[1:0], irq_signal_mode_o);
			chk("lv", m[0], low_volt_capable_force_o);
		end
		// low byte lane off: answered but nothing stored
		s_axi_wstrb_i <= 4'he;
		wr(12'h248, 8'h00, RESP_OKAY);
		s_axi_wstrb_i <= 4'hf;
		rc(12'h248, 8'h66);
		wr(12'h24c, 8'h00, RESP_OKAY);
		rc(12'h24c, 8'h00);
	endtask
	task t_speaker;
		lvl.speaker <= 2'b10;
		wr(12'h244, 8'h5e, RESP_OKAY);
		rc(12'h244, 8'h46);
		settle;
		chk("float", 2'b01, video_port_float_en_o);
		chk("spk", 0, speaker_out_pin_o);
		chk("oe", 1, speaker_out_oe_o);
		wr(12'h644, 8'h02, RESP_OKAY);
		settle;
		chk("spk", 1, speaker_out_pin_o);
		lvl.speaker <= 2'b11;
		settle;
		chk("spk", 0, speaker_out_pin_o);
		wr(12'h244, 8'h00, RESP_OKAY);
		wr(12'h644, 8'h00, RESP_OKAY);
		settle;
		chk("oe", 0, speaker_out_oe_o);
	endtask
	task t_audio_video;
		lvl.audio <= 2'b10;
		wr(12'h244, 8'h64, RESP_OKAY);
		wr(12'h644, 8'h44, RESP_OKAY);
		settle;
		chk("pwm", 0, card_audio_pwm_out_o);
		chk("sel", 2'b10, {video_sel_sock1_o, video_sel_sock0_o});
		wr(12'h244, 8'h44, RESP_OKAY);
		settle;
		chk("sel", 2'b01, {video_sel_sock1_o, video_sel_sock0_o});
		wr(12'h244, 8'h00, RESP_OKAY);
		settle;
		chk("pwm", 1, card_audio_pwm_out_o);
		wr(12'h644, 8'h00, RESP_OKAY);
	endtask
	task t_ring;
		lvl.ring <= 2'b01;
		wr(12'h244, 8'h80, RESP_OKAY);
		settle;
		chk("ring", 2'b11, {ring_indicate_out_o, ring_mfunc_out_o});
		rc(12'h644, 8'h80);
		ring_mux_select_i <= 1;
		settle;
		chk("ring", 2'b01, {ring_indicate_out_o, ring_mfunc_out_o});
		wr(12'h244, 8'h00, RESP_OKAY);
		settle;
		chk("ring", 2'b00, {ring_indicate_out_o, ring_mfunc_out_o});
	endtask
	task t_irq;
		lvl.func_irq <= 2'b11;
		settle;
		lvl.func_irq <= 2'b00;
		settle;
		chk("flag", 2'b11, card_func_irq_flag_o);
		rc(12'h644, 8'h01);
		wr(12'h644, 8'h00, RESP_OKAY);
		chk("flag", 2'b11, card_func_irq_flag_o);
		// clearing one socket's flag leaves the other set
		wr(12'h644, 8'h01, RESP_OKAY);
		settle;
		chk("flag", 2'b01, card_func_irq_flag_o);
		wr(12'h244, 8'h01, RESP_OKAY);
		settle;
		chk("flag", 2'b00, card_func_irq_flag_o);
		wr(12'h800, 8'h01, RESP_SLVERR);
		rd(12'h800);
		chk("rresp", RESP_SLVERR, r);
		chk("rdata", 32'h0, d);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		sys_rst_i = 1;
		ring_mux_select_i = 0;
		lvl = '0;
		s_axi_awaddr_i = '0;
		s_axi_araddr_i = '0;
		s_axi_wdata_i = '0;
		s_axi_wstrb_i = 4'hf;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		repeat (5) @(posedge clock_i);
		sys_rst_i <= 0;
		t_reset;
		t_dev;
		t_speaker;
		t_audio_video;
		t_ring;
		t_irq;
		finish_test;
	end
endmodule // tb
